// [src/ccpu_unit.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_consts.svh"
module ccpu_unit
  import ccpu_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [15:0] i_timer_count,
  input  wire logic        i_pin,
  output logic             o_pin,
  output logic             o_pin_oe_n,
  output logic             o_timer_reset,
  output logic             o_adc_start,
  output logic             o_event_flag
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ccpu_bus_type  bus;            // Bundled request.
  ccpu_mode_type mode;           // Decoded mode.
  logic [7:0]    value_low;      // Low byte of value pair / duty MSBs.
  logic [7:0]    value_high;     // High byte / latched duty in PWM.
  logic [7:0]    control;        // Mode select and duty low bits.
  logic [7:0]    period;         // Timer2 period value.
  logic [7:0]    t2ctrl;         // Bit 2 run, bits 1:0 prescale.
  logic [7:0]    t2count;        // Timer2 count.
  logic [3:0]    t2pre;          // Timer2 prescaler counter.
  logic [1:0]    qclk;           // Quarter-cycle bits.
  logic [1:0]    duty_latch;     // Latched two duty LSBs.
  logic [3:0]    cap_pre;        // Capture prescaler counter.
  logic          out_latch;      // Compare/PWM output latch.
  logic          pin_level;      // Synchronised pin.
  logic          pin_rise;       // Synchronised rising edge.
  logic          pin_fall;       // Synchronised falling edge.
  logic          cap_hit;        // Capture event this cycle.
  logic          match;          // Compare match this cycle.
  logic          t2_tick;        // Timer2 increments this cycle.
  logic          t2_wrap;        // Period complete on this increment.
  logic [7:0]    next_t2count;   // Timer2 count after this edge.
  logic [3:0]    next_t2pre;     // Timer2 prescaler after this edge.
  logic [9:0]    next_ext;       // Extended timer2 after this edge.
  logic [9:0]    duty_now;       // Latched 10-bit duty.
  logic          sw_clr;         // Software clears the event flag.
  logic [3:0]    pre_last;       // Prescaler terminal count.
  logic          match_q;        // Pair/timer equality seen last cycle.

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Reserved codes 0001..0011 behave as off.
  always_comb begin
    mode = CCPU_OFF;
    if (control[3:2] == 2'b11) begin
      mode = CCPU_PWM;
    end else if (control[3:2] == 2'b01) begin
      mode = CCPU_CAPTURE;
    end else if (control[3:2] == 2'b10) begin
      unique case (control[1:0])
        2'b00: mode = CCPU_CMP_SET;
        2'b01: mode = CCPU_CMP_CLR;
        2'b10: mode = CCPU_CMP_SOFT;
        2'b11: mode = CCPU_CMP_TRIG;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // The raw pin is sampled regardless of direction, so a port write
  // that moves a driven pin still produces an edge.
  ccpu_pin_sync u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_pin),
    .o_level  (pin_level),
    .o_rise   (pin_rise),
    .o_fall   (pin_fall)
  );

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  assign pre_last = control[0] ? `CCPU_PRE16_LAST : `CCPU_PRE4_LAST;

  always_comb begin
    cap_hit = 1'b0;
    if (mode == CCPU_CAPTURE) begin
      unique case (control[1:0])
        2'b00: cap_hit = pin_fall;
        2'b01: cap_hit = pin_rise;
        default: cap_hit = pin_rise && (cap_pre == pre_last);
      endcase
    end
  end

  // Prescaler counter; a direct switch between the two prescale settings keeps
  // its count because only leaving capture mode or a single-edge setting clears it.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cap_pre <= 4'h0;
    end else if (mode != CCPU_CAPTURE || !control[1]) begin
      cap_pre <= 4'h0;
    end else if (pin_rise) begin
      cap_pre <= (cap_pre >= pre_last) ? 4'h0 : cap_pre + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // One match per equal window: the timer may hold a value for many
  // core cycles, so only the first cycle of equality counts.
  always_comb begin
    match = 1'b0;
    if (mode == CCPU_CMP_SET || mode == CCPU_CMP_CLR ||
        mode == CCPU_CMP_SOFT || mode == CCPU_CMP_TRIG) begin
      match = ({value_high, value_low} == i_timer_count) && !match_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      match_q <= 1'b0;
    end else begin
      match_q <= ({value_high, value_low} == i_timer_count);
    end
  end

  // Special event trigger pulses; timer resets here never touch the
  // overflow flag, which lives outside and sees only this strobe.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timer_reset <= 1'b0;
      o_adc_start   <= 1'b0;
    end else begin
      o_timer_reset <= match && mode == CCPU_CMP_TRIG;
      o_adc_start   <= match && mode == CCPU_CMP_TRIG;
    end
  end

  // ----------------------------------------------------------------
  // Timer2 time base
  // ----------------------------------------------------------------
  // Quarter-cycle bits run always; prescale 1, 4 or 16.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      qclk <= 2'b00;
    end else begin
      qclk <= qclk + 2'b01;
    end
  end

  always_comb begin
    unique case (t2ctrl[1:0])
      2'b00:   t2_tick = t2ctrl[2] && qclk == 2'b11;
      2'b01:   t2_tick = t2ctrl[2] && qclk == 2'b11 && t2pre[1:0] == 2'b11;
      default: t2_tick = t2ctrl[2] && qclk == 2'b11 && t2pre == 4'hF;
    endcase
  end

  // Postscaler is not modelled: the period depends only on these.
  assign t2_wrap = t2_tick && (t2count == period);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      t2pre   <= 4'h0;
      t2count <= 8'h00;
    end else begin
      if (qclk == 2'b11) begin
        t2pre <= t2pre + 4'h1;
      end
      if (t2_wrap) begin
        t2count <= 8'h00;
      end else if (t2_tick) begin
        t2count <= t2count + 8'h01;
      end
    end
  end

  // Fine bits: quarter clock at prescale 1, prescaler bits otherwise.
  // The compare looks at the value the extended count takes at the
  // coming edge. The set also lands on the edge that starts the period,
  // so the high time is exactly the duty count; comparing the present
  // value instead would stretch every pulse by one clock.
  always_comb begin
    next_t2count = t2count;
    if (t2_wrap) begin
      next_t2count = 8'h00;
    end else if (t2_tick) begin
      next_t2count = t2count + 8'h01;
    end
    next_t2pre = (qclk == 2'b11) ? t2pre + 4'h1 : t2pre;
    unique case (t2ctrl[1:0])
      2'b00:   next_ext = {next_t2count, qclk + 2'b01};
      2'b01:   next_ext = {next_t2count, next_t2pre[1:0]};
      default: next_ext = {next_t2count, next_t2pre[3:2]};
    endcase
  end

  assign duty_now = {value_high, duty_latch};

  // ----------------------------------------------------------------
  // Output latch
  // ----------------------------------------------------------------
  // Period start sets the pin unless duty is zero; a duty beyond the
  // period never equals the count, so the pin stays high.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_latch <= 1'b0;
    end else if (bus.wr && bus.addr == `CCPU_OFF_CONTROL && bus.wdata == 8'h00) begin
      out_latch <= 1'b0;
    end else if (mode == CCPU_PWM) begin
      if (t2_wrap) begin
        out_latch <= ({value_low, control[5:4]} != 10'h000);
      end else if (next_ext == duty_now) begin
        out_latch <= 1'b0;
      end
    end else if (match && mode == CCPU_CMP_SET) begin
      out_latch <= 1'b1;
    end else if (match && mode == CCPU_CMP_CLR) begin
      out_latch <= 1'b0;
    end
  end

  // Pin outputs: drive only in compare-drive and PWM modes.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin      <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else begin
      o_pin      <= out_latch;
      o_pin_oe_n <= !(mode == CCPU_PWM || mode == CCPU_CMP_SET || mode == CCPU_CMP_CLR);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      control <= `CCPU_RST_CONTROL;
      period  <= `CCPU_RST_PERIOD;
      t2ctrl  <= `CCPU_RST_T2CTRL;
    end else if (bus.wr) begin
      if (bus.addr == `CCPU_OFF_CONTROL) begin
        control <= {2'b00, bus.wdata[5:0]};
      end
      if (bus.addr == `CCPU_OFF_PERIOD) begin
        period <= bus.wdata;
      end
      if (bus.addr == `CCPU_OFF_T2CTRL) begin
        t2ctrl <= {5'h00, bus.wdata[2:0]};
      end
    end
  end

  // Value pair: capture wins over a software write in the same cycle.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      value_low  <= 8'h00;
      value_high <= 8'h00;
      duty_latch <= 2'b00;
    end else if (cap_hit) begin
      value_low  <= i_timer_count[7:0];
      value_high <= i_timer_count[15:8];
    end else begin
      if (bus.wr && bus.addr == `CCPU_OFF_VALUE_LOW) begin
        value_low <= bus.wdata;
      end
      if (mode == CCPU_PWM) begin
        if (t2_wrap) begin
          value_high <= value_low;
          duty_latch <= control[5:4];
        end
      end else if (bus.wr && bus.addr == `CCPU_OFF_VALUE_HIGH) begin
        value_high <= bus.wdata;
      end
    end
  end

  // Event flag: set wins over software clear (write 1 to bit 5 clears).
  // A mode change can raise a stray edge or match, which sets it too.
  assign sw_clr = bus.wr && bus.addr == `CCPU_OFF_FLAGS && bus.wdata[`CCPU_FLAG_EVENT_BIT];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_event_flag <= 1'b0;
    end else if (cap_hit || match) begin
      o_event_flag <= 1'b1;
    end else if (sw_clr) begin
      o_event_flag <= 1'b0;
    end
  end

  // Read data stand one cycle after the read strobe, zero otherwise.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `CCPU_OFF_VALUE_LOW:  o_rdata <= value_low;
        `CCPU_OFF_VALUE_HIGH: o_rdata <= value_high;
        `CCPU_OFF_CONTROL:    o_rdata <= control;
        `CCPU_OFF_FLAGS:      o_rdata <= {2'b00, o_event_flag, 4'h0, pin_level};
        `CCPU_OFF_PERIOD:     o_rdata <= period;
        `CCPU_OFF_T2CTRL:     o_rdata <= t2count;
        default:              o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [src/ccpu_consts.svh]
`ifndef CCPU_CONSTS_SVH
`define CCPU_CONSTS_SVH
// Register offsets (byte addresses on the plain register port).
`define CCPU_OFF_VALUE_LOW   8'h13
`define CCPU_OFF_VALUE_HIGH  8'h14
`define CCPU_OFF_CONTROL     8'h15
// Extra registers: event flag/status and timer2 period/control.
`define CCPU_OFF_FLAGS       8'h16
`define CCPU_OFF_PERIOD      8'h17
`define CCPU_OFF_T2CTRL      8'h18
// Field positions.
`define CCPU_FLAG_EVENT_BIT  5
`define CCPU_FLAG_OVF_BIT    0
`define CCPU_CTRL_DUTY_LSB   4
// Reset values.
`define CCPU_RST_CONTROL     8'h00
`define CCPU_RST_PERIOD      8'hFF
`define CCPU_RST_T2CTRL      8'h00
// Capture prescaler terminal counts.
`define CCPU_PRE4_LAST       4'h3
`define CCPU_PRE16_LAST      4'hF
`endif

// [src/ccpu_pkg.sv]
package ccpu_pkg;
  // Bus request carrier.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccpu_bus_type;

  // Unit mode decoded from the mode select field.
  typedef enum logic [2:0] {
    CCPU_OFF,
    CCPU_CAPTURE,
    CCPU_CMP_SET,
    CCPU_CMP_CLR,
    CCPU_CMP_SOFT,
    CCPU_CMP_TRIG,
    CCPU_PWM
  } ccpu_mode_type;
endpackage

// [src/ccpu_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser: a change counts once stages two and three agree.
module ccpu_pin_sync
  import ccpu_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic s1;  // First stage, read only by s2.
  logic s2;  // Second stage.
  logic s3;  // Third stage.

  // Shift the pin through three flops.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered level follows once two and three agree; edges from it.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level <= 1'b0;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (s2 == s3 && s3 != o_level) begin
        o_level <= s3;
        o_rise  <= s3;
        o_fall  <= !s3;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/ccpu_unit_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ccpu_unit_sva
  import ccpu_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic [15:0] i_timer_count,
  input wire logic        i_pin,
  input wire logic        o_pin,
  input wire logic        o_pin_oe_n,
  input wire logic        o_timer_reset,
  input wire logic        o_adc_start,
  input wire logic        o_event_flag
);
  // ------------------------------------------------------------
  // Shadow of software writes.
  // ------------------------------------------------------------
  logic [7:0]  ctl;    // Last control byte written.
  logic [15:0] pair;   // Last value pair written.
  logic [1:0]  pv;     // Which bytes of the shadow pair are trusted.
  logic [3:0]  age;    // Cycles since a value or control write.
  logic        clr_q;  // A flag clear or control write one cycle ago.
  logic        z_q;    // A control write of zero one cycle ago.
  wire         wsel = i_wr && i_addr >= 8'h13 && i_addr <= 8'h15;
  wire         clr  = i_wr && (i_addr == 8'h15 || (i_addr == 8'h16 && i_wdata[5]));
  wire         drv  = ctl[3] && (ctl[2] || !ctl[1]);
  // Captures and duty reloads overwrite the pair, so trust is dropped there.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl   <= 8'h00;
      pair  <= 16'h0000;
      pv    <= 2'h0;
      age   <= 4'h0;
      clr_q <= 1'b0;
      z_q   <= 1'b0;
    end else begin
      clr_q <= clr;
      z_q   <= i_wr && i_addr == 8'h15 && i_wdata == 8'h00;
      age   <= wsel ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
      pv    <= ctl[2] ? 2'h0 : pv | {i_wr && i_addr == 8'h14, i_wr && i_addr == 8'h13};
      if (i_wr && i_addr == 8'h15) begin
        ctl <= i_wdata;
      end
      if (i_wr && i_addr == 8'h13) begin
        pair[7:0] <= i_wdata;
      end
      if (i_wr && i_addr == 8'h14) begin
        pair[15:8] <= i_wdata;
      end
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  a_adc_with_trig: assert property (o_adc_start == o_timer_reset)
    else $error("conversion start and timer reset differ");
  a_trig_one_pulse: assert property (o_timer_reset |=> !o_timer_reset)
    else $error("timer reset longer than one cycle");
  a_trig_mode_only: assert property (o_timer_reset && age >= 4'h3 |-> ctl[3:0] == 4'hB)
    else $error("timer reset outside trigger mode");
  a_drive_by_mode: assert property (age >= 4'h3 |-> o_pin_oe_n == !drv)
    else $error("pin enable wrong for mode");
  a_soft_keeps_pin: assert property (age >= 4'h3 && ctl[3:1] == 3'b101 |=> $stable(o_pin))
    else $error("pin moved in flag-only mode");
  a_flag_sticky: assert property (o_event_flag && !clr && !clr_q |=> o_event_flag)
    else $error("event flag dropped by itself");
  a_zero_clears_latch: assert property (z_q |=> !o_pin && o_pin_oe_n)
    else $error("output latch not cleared");
  a_ctrl_readback: assert property ($past(i_rd) && $past(i_addr) == 8'h15 |-> o_rdata == {2'b00, ctl[5:0]})
    else $error("control readback wrong");
  a_match_sets_flag: assert property (age >= 4'h3 && &pv && ctl[3:2] == 2'b10 && i_timer_count == pair
    && $past(i_timer_count) != pair |-> ##[1:3] o_event_flag)
    else $error("compare match without flag");
  c_capture: cover property (ctl[3:2] == 2'b01 ##1 $rose(o_event_flag));
  c_trigger: cover property (o_timer_reset);
  c_pwm_high: cover property (ctl[3:2] == 2'b11 && $rose(o_pin));
endmodule
bind ccpu_unit ccpu_unit_sva u_ccpu_unit_sva (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_count(i_timer_count), .i_pin(i_pin), .o_pin(o_pin),
  .o_pin_oe_n(o_pin_oe_n), .o_timer_reset(o_timer_reset), .o_adc_start(o_adc_start),
  .o_event_flag(o_event_flag)
);
`default_nettype wire

// [tb/ccpu_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Far side of the shared pin: a port driver or an open line.
// ------------------------------------------------------------
module ccpu_pin_model
  import ccpu_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_drive_en,   // The outside source drives the line.
  input  wire logic i_drive_lvl,  // Level the outside source drives.
  input  wire logic i_pin_q,      // Output latch of the unit.
  input  wire logic i_pin_oe_n,   // Unit drives the line while low.
  output logic      o_line
);
  logic float_q = 1'b0;  // Undriven line wanders, so nothing may rely on it.
  always_ff @(posedge i_mclk) begin
    float_q <= ~float_q;
  end
  // The unit sees the real line level, its own drive included.
  always_comb begin
    if (!i_pin_oe_n) begin
      o_line = i_pin_q;
    end else if (i_drive_en) begin
      o_line = i_drive_lvl;
    end else begin
      o_line = float_q;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  // ------------------------------------------------------------
  // Stimulus and observed signals.
  // ------------------------------------------------------------
  ccpu_pkg::ccpu_bus_type bus;  // Register port request.
  logic        i_mclk;
  logic        i_resetn;
  logic [7:0]  o_rdata;
  logic [15:0] i_timer_count;   // Timer changes only on clock edges.
  logic        pin_line;
  logic        o_pin;
  logic        o_pin_oe_n;
  logic        o_timer_reset;
  logic        o_adc_start;
  logic        o_event_flag;
  logic        src_en;
  logic        src_lvl;
  int          checked;
  int          bad_count;
  int          cyc;
  ccpu_unit u_ccpu_unit (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(bus.addr), .i_wdata(bus.wdata), .i_wr(bus.wr),
    .i_rd(bus.rd), .o_rdata(o_rdata), .i_timer_count(i_timer_count), .i_pin(pin_line),
    .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_timer_reset(o_timer_reset),
    .o_adc_start(o_adc_start), .o_event_flag(o_event_flag)
  );
  ccpu_pin_model u_ccpu_pin_model (
    .i_mclk(i_mclk), .i_drive_en(src_en), .i_drive_lvl(src_lvl), .i_pin_q(o_pin),
    .i_pin_oe_n(o_pin_oe_n), .o_line(pin_line)
  );
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // ------------------------------------------------------------
  // Bus cycles and helpers.
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask
  // One high pulse on the line, with the timer parked at t meanwhile.
  task automatic pulse(input logic [15:0] t);
    @(posedge i_mclk);
    i_timer_count <= t;
    src_lvl       <= 1'b1;
    tick(8);
    src_lvl <= 1'b0;
    tick(8);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    `CHK("oe_n", 1'b1, o_pin_oe_n)
    `CHK("pin", 1'b0, o_pin)
    rd8(8'h15, d);
    `CHK("control", 8'h00, d)
    rd8(8'h00, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  // Every capture code; the last edge of each run carries a fresh timer value.
  task automatic t_capture();
    logic [7:0] lo;
    logic [7:0] hi;
    int         n;
    for (int m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : ((m == 7) ? 16 : 2);
      wr8(8'h15, 8'h00);
      wr8(8'h15, {4'h0, 4'(m)});
      wr8(8'h16, 8'h20);
      repeat (n - 1) pulse(16'h1111);
      `CHK("early flag", 1'(m < 6), o_event_flag)
      pulse({12'hC00, 4'(m)});
      `CHK("flag", 1'b1, o_event_flag)
      rd8(8'h13, lo);
      rd8(8'h14, hi);
      `CHK("capture", {12'hC00, 4'(m)}, {hi, lo})
    end
    rd8(8'h16, lo);
    `CHK("flag bit", 1'b1, lo[5])
    wr8(8'h16, 8'h20);
    tick(2);
    `CHK("flag cleared", 1'b0, o_event_flag)
  endtask
  // Compare codes in the order clear, set, soft, trigger: latch stays low, is set, then is kept.
  task automatic t_compare();
    logic [3:0] md [4] = '{4'h9, 4'h8, 4'hA, 4'hB};
    logic       pv [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    int         trig;
    src_en <= 1'b0;
    wr8(8'h15, 8'h00);
    wr8(8'h13, 8'h34);
    wr8(8'h14, 8'h12);
    for (int k = 0; k < 4; k++) begin
      i_timer_count <= 16'h0000;
      wr8(8'h15, {4'h0, md[k]});
      wr8(8'h16, 8'h20);
      tick(3);
      `CHK("quiet flag", 1'b0, o_event_flag)
      i_timer_count <= 16'h1234;
      trig = 0;
      repeat (8) begin
        @(posedge i_mclk);
        trig += int'(o_timer_reset === 1'b1 && o_adc_start === 1'b1);
      end
      `CHK("trigger", int'(md[k] == 4'hB), trig)
      `CHK("match flag", 1'b1, o_event_flag)
      `CHK("latch", pv[k], o_pin)
      `CHK("drive", 1'(k > 1), o_pin_oe_n)
    end
    wr8(8'h15, 8'h00);
    tick(3);
    `CHK("latch off", 1'b0, o_pin)
  endtask
  // Measures a full high time and period once the new duty is loaded.
  task automatic meas(input logic [7:0] lo, input logic [5:0] cfg, input logic [7:0] t2, input int h_ex,
                      input int p_ex);
    int h;
    int p;
    wr8(8'h18, t2);
    wr8(8'h13, lo);
    wr8(8'h15, {2'b00, cfg});
    p = 0;
    while (o_pin !== 1'b1 && p < 300) begin
      @(posedge i_mclk);
      p++;
    end
    repeat (2) begin
      h = 0;
      while (o_pin === 1'b1 && h < 300) begin
        @(posedge i_mclk);
        h++;
      end
      p = h;
      while (o_pin !== 1'b1 && p < 300) begin
        @(posedge i_mclk);
        p++;
      end
    end
    `CHK("high time", h_ex, h)
    `CHK("period", p_ex, p)
  endtask
  task automatic level_run(input logic lvl, output int n);
    n = 0;
    repeat (32) begin
      @(posedge i_mclk);
      n += int'(o_pin === lvl);
    end
  endtask
  task automatic t_pwm();
    logic [7:0] d;
    int         n;
    wr8(8'h17, 8'h03);
    meas(8'h02, 6'h0C, 8'h04, 8, 16);
    wr8(8'h14, 8'hEE);
    rd8(8'h14, d);
    `CHK("duty high", 8'h02, d)
    meas(8'h01, 6'h2C, 8'h04, 6, 16);
    meas(8'h02, 6'h0C, 8'h05, 32, 64);
    meas(8'h02, 6'h0C, 8'h06, 128, 256);
    wr8(8'h18, 8'h04);
    wr8(8'h13, 8'h10);
    tick(48);
    level_run(1'b1, n);
    `CHK("long duty", 32, n)
    wr8(8'h13, 8'h00);
    tick(48);
    level_run(1'b0, n);
    `CHK("zero duty", 32, n)
  endtask
  // ------------------------------------------------------------
  // Main sequence and hang guard.
  // ------------------------------------------------------------
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    bus           = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    i_resetn      = 1'b0;
    i_timer_count = 16'h0000;
    src_en        = 1'b1;
    src_lvl       = 1'b0;
    checked       = 0;
    bad_count     = 0;
    cyc           = 0;
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(negedge i_mclk);
    t_reset();
    t_capture();
    t_compare();
    t_pwm();
    finish_test();
  end
endmodule
`default_nettype wire
